// [hw/mirq_mode0_seq.sv]
// Mode 0 maskable interrupt response sequencer of the core.
// Assumes the core stalls while busy_out is high and samples loads on their pulses.
`timescale 1ns/100ps
`include "mirq_regs.svh"
module mirq_mode0_seq
    import mirq_pkg::*;
#(
    parameter int PC_W = 24,
    parameter int DATA_W = 8
)
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // Core side
    input wire mirq_core_ctl_t ctl_in,
    input wire logic irq_req_in,
    input wire logic [PC_W-1:0] pc_in,
    input wire logic [7:0] short_mode_page_base_in,
    input wire logic [15:0] sps_in,
    input wire logic [PC_W-1:0] spl_in,
    // Peripheral data bus
    input wire logic [DATA_W-1:0] ack_data_in,
    output logic iack_out,
    // Memory writes
    output mirq_mem_wr_t mem_out,
    // Loads back to the core
    output mirq_load_t load_out,
    // Mode and flag state
    output logic maskable_enable_flag_out,
    output logic enable_flag_shadow_out,
    output logic long_address_mode_bit_out,
    output logic mixed_mode_irq_bit_out,
    output logic [1:0] irq_mode_out,
    output logic busy_out,
    output logic done_out,
    output logic nop_out
);
    generate
        if (PC_W != 24 || DATA_W != 8)
        begin : g_bad_width
            $error("mirq_mode0_seq serves a 24-bit counter and 8-bit bus only");
        end
    endgenerate

    mirq_regs_t cur_ff;
    mirq_regs_t nxt_cur;
    logic [23:0] push_addr;
    logic [7:0] push_data;
    logic [2:0] push_cnt;
    logic [23:0] push_sp_end;

    mirq_push_byte u_push
    (
        .adl_in(cur_ff.adl_e),
        .mixed_mode_irq_bit_in(cur_ff.mixed_mode_irq_bit_e),
        .short_mode_page_base_in(short_mode_page_base_in),
        .sps_in(sps_in),
        .spl_in(spl_in),
        .ret_pc_in(cur_ff.ret_pc),
        .idx_in(cur_ff.push_idx),
        .addr_out(push_addr),
        .data_out(push_data),
        .count_out(push_cnt),
        .sp_end_out(push_sp_end)
    );

    logic accept;
    logic is_rst;
    logic is_call;
    logic [7:0] rst_nn;
    logic opnd_last;

    // Acknowledge byte decode, kept apart from the state update
    always_comb
    begin
        // Not at the enable instruction's own boundary
        accept = ctl_in.boundary && irq_req_in && cur_ff.maskable_enable_flag && !ctl_in.ei
            && (cur_ff.im_mode == `MIRQ_IM_ZERO) && (cur_ff.st == MIRQ_IDLE);
        // Suffix opcodes are assumed never to appear here
        case (ack_data_in)
            `MIRQ_RST_00,
            `MIRQ_RST_08,
            `MIRQ_RST_10,
            `MIRQ_RST_18,
            `MIRQ_RST_20,
            `MIRQ_RST_28,
            `MIRQ_RST_30,
            `MIRQ_RST_38:
            begin
                is_rst = 1'b1;
                is_call = 1'b0;
            end
            `MIRQ_OPC_CALL:
            begin
                is_rst = 1'b0;
                is_call = 1'b1;
            end
            default:
            begin
                // Anything else ends as a no-operation
                is_rst = 1'b0;
                is_call = 1'b0;
            end
        endcase
        rst_nn = ack_data_in & `MIRQ_RST_VEC;
        if (cur_ff.lng)
        begin
            opnd_last = cur_ff.opnd_cnt == `MIRQ_OPND_LAST_LONG;
        end
        else
        begin
            opnd_last = cur_ff.opnd_cnt == `MIRQ_OPND_LAST_SHORT;
        end
    end

    always_comb
    begin
        nxt_cur = cur_ff;
        nxt_cur.done = 1'b0;
        nxt_cur.nop = 1'b0;
        nxt_cur.mem.wr = 1'b0;
        nxt_cur.ld.pc_load = 1'b0;
        nxt_cur.ld.sp_load = 1'b0;

        // Instruction effects on flags and modes
        if (ctl_in.ei)
        begin
            nxt_cur.maskable_enable_flag = 1'b1;
            nxt_cur.enable_flag_shadow = 1'b1;
        end
        if (ctl_in.di)
        begin
            nxt_cur.maskable_enable_flag = 1'b0;
            nxt_cur.enable_flag_shadow = 1'b0;
        end
        if (ctl_in.sel_im0)
        begin
            nxt_cur.im_mode = `MIRQ_IM_ZERO;
        end
        if (ctl_in.sel_im1)
        begin
            nxt_cur.im_mode = `MIRQ_IM_ONE;
        end
        if (ctl_in.sel_im2)
        begin
            nxt_cur.im_mode = `MIRQ_IM_TWO;
        end
        if (ctl_in.set_mix)
        begin
            nxt_cur.mixed_mode_irq_bit = 1'b1;
        end
        if (ctl_in.clr_mix)
        begin
            nxt_cur.mixed_mode_irq_bit = 1'b0;
        end
        if (ctl_in.adl_wr)
        begin
            nxt_cur.long_address_mode_bit = ctl_in.adl_val;
        end

        case (cur_ff.st)
            MIRQ_IDLE:
            begin
                if (accept)
                begin
                    nxt_cur.st = MIRQ_OPCODE;
                    nxt_cur.busy = 1'b1;
                    nxt_cur.iack = 1'b1;
                    nxt_cur.ret_pc = pc_in;
                    nxt_cur.adl_e = cur_ff.long_address_mode_bit;
                    nxt_cur.mixed_mode_irq_bit_e = cur_ff.mixed_mode_irq_bit;
                    nxt_cur.lng = cur_ff.long_address_mode_bit | cur_ff.mixed_mode_irq_bit;
                    nxt_cur.opnd = `MIRQ_ZERO_WORD;
                    nxt_cur.opnd_cnt = 2'h0;
                    nxt_cur.push_idx = 3'h0;
                end
            end
            MIRQ_OPCODE:
            begin
                // Byte is taken in the cycle iack is high
                if (is_rst)
                begin
                    nxt_cur.iack = 1'b0;
                    nxt_cur.st = MIRQ_PUSH;
                    if (cur_ff.lng)
                    begin
                        nxt_cur.target = {`MIRQ_ZERO_WORD, rst_nn};
                    end
                    else
                    begin
                        nxt_cur.target = {short_mode_page_base_in, `MIRQ_ZERO_BYTE, rst_nn};
                    end
                end
                else if (is_call)
                begin
                    nxt_cur.st = MIRQ_OPERAND;
                end
                else
                begin
                    // Unknown byte: no push, no flag change
                    nxt_cur.iack = 1'b0;
                    nxt_cur.busy = 1'b0;
                    nxt_cur.nop = 1'b1;
                    nxt_cur.done = 1'b1;
                    nxt_cur.st = MIRQ_IDLE;
                end
            end
            MIRQ_OPERAND:
            begin
                if (opnd_last)
                begin
                    nxt_cur.iack = 1'b0;
                    nxt_cur.st = MIRQ_PUSH;
                    if (cur_ff.lng)
                    begin
                        nxt_cur.target = {ack_data_in, cur_ff.opnd};
                    end
                    else
                    begin
                        nxt_cur.target = {short_mode_page_base_in, ack_data_in, cur_ff.opnd[7:0]};
                    end
                end
                else
                begin
                    // Low byte first
                    if (cur_ff.opnd_cnt == 2'h0)
                    begin
                        nxt_cur.opnd[7:0] = ack_data_in;
                    end
                    else
                    begin
                        nxt_cur.opnd[15:8] = ack_data_in;
                    end
                    nxt_cur.opnd_cnt = cur_ff.opnd_cnt + 2'h1;
                end
            end
            MIRQ_PUSH:
            begin
                nxt_cur.mem.wr = 1'b1;
                nxt_cur.mem.addr = push_addr;
                nxt_cur.mem.data = push_data;
                if (cur_ff.push_idx == push_cnt - 3'h1)
                begin
                    nxt_cur.st = MIRQ_FINISH;
                end
                else
                begin
                    nxt_cur.push_idx = cur_ff.push_idx + 3'h1;
                end
            end
            MIRQ_FINISH:
            begin
                nxt_cur.maskable_enable_flag = 1'b0;
                nxt_cur.enable_flag_shadow = 1'b0;
                // Mixed mode starts every routine long; short mode keeps it clear
                if (cur_ff.mixed_mode_irq_bit_e)
                begin
                    nxt_cur.long_address_mode_bit = 1'b1;
                end
                else
                begin
                    nxt_cur.long_address_mode_bit = cur_ff.adl_e;
                end
                nxt_cur.ld.pc_load = 1'b1;
                nxt_cur.ld.pc_val = cur_ff.target;
                nxt_cur.ld.sp_load = 1'b1;
                nxt_cur.ld.sp_long = cur_ff.lng;
                nxt_cur.ld.sp_val = push_sp_end;
                nxt_cur.busy = 1'b0;
                nxt_cur.done = 1'b1;
                nxt_cur.st = MIRQ_IDLE;
            end
            default:
            begin
                nxt_cur.st = MIRQ_IDLE;
                nxt_cur.busy = 1'b0;
                nxt_cur.iack = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cur_ff <= '0; // mode 0, flags clear
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign iack_out = cur_ff.iack;
    assign mem_out = cur_ff.mem;
    assign load_out = cur_ff.ld;
    assign maskable_enable_flag_out = cur_ff.maskable_enable_flag;
    assign enable_flag_shadow_out = cur_ff.enable_flag_shadow;
    assign long_address_mode_bit_out = cur_ff.long_address_mode_bit;
    assign mixed_mode_irq_bit_out = cur_ff.mixed_mode_irq_bit;
    assign irq_mode_out = cur_ff.im_mode;
    assign busy_out = cur_ff.busy;
    assign done_out = cur_ff.done;
    assign nop_out = cur_ff.nop;
endmodule

// [hw/mirq_regs.svh]
// Constants of the mode 0 maskable interrupt response sequencer.
// Assumes a core that stalls at an instruction boundary while the sequencer is busy.
//
// What this block does
// - Three maskable response modes exist, picked by mode-select instructions; reset and the mode zero select pick mode 0.
// - A restart opcode is one of C7h, CFh, D7h, DFh, E7h, EFh, F7h or FFh, each with a fixed target.
// - The call opcode CDh may also be supplied, and the core then vectors to the address in its operand bytes.
// - Any other acknowledge byte is executed as a no-operation.
// - Accepting a mode 0 interrupt with a restart or call byte clears the enable flag and its shadow in every mode combination.
// - With both mode bits 0, the 2-byte return address goes on the short stack at page base and short pointer, long mode staying 0.
// - With both mode bits 0, the low 16 program counter bits load {00h, nn} or {mm, nn} under the page base.
// - With long mode 1, the 3-byte return address goes on the long stack whatever the mixed bit.
// - With long mode 0 and mixed 1, the 2-byte return address then byte 02h go on the long stack, and long mode is set.
// - With both bits 1, byte 03h follows the 3-byte return address on the long stack, long mode staying 1.
// - When either bit is 1, the 24-bit program counter loads {0000h, nn} or {MM, mm, nn}.
// - An interrupt is accepted only with the enable flag at 1, and not at the boundary of the enable instruction itself.
// - The mixed bit is set by its own instruction, and when set every service routine starts in long mode.
`ifndef MIRQ_REGS_SVH
`define MIRQ_REGS_SVH

`define MIRQ_IM_ZERO 2'h0
`define MIRQ_IM_ONE 2'h1
`define MIRQ_IM_TWO 2'h2
`define MIRQ_RST_00 8'hC7
`define MIRQ_RST_08 8'hCF
`define MIRQ_RST_10 8'hD7
`define MIRQ_RST_18 8'hDF
`define MIRQ_RST_20 8'hE7
`define MIRQ_RST_28 8'hEF
`define MIRQ_RST_30 8'hF7
`define MIRQ_RST_38 8'hFF
`define MIRQ_RST_VEC 8'h38
`define MIRQ_OPC_CALL 8'hCD
`define MIRQ_MIX_FROM_SHORT 8'h02
`define MIRQ_MIX_FROM_LONG 8'h03
`define MIRQ_OPND_LAST_SHORT 2'h1
`define MIRQ_OPND_LAST_LONG 2'h2
`define MIRQ_PUSH_SHORT 3'h2
`define MIRQ_PUSH_LONG 3'h3
`define MIRQ_ZERO_BYTE 8'h00
`define MIRQ_ZERO_WORD 16'h0000

`endif

// [hw/mirq_pkg.sv]
// Types of the mode 0 maskable interrupt response sequencer.
// Assumes the constants header is included by every user.
package mirq_pkg;

    typedef enum logic [2:0] {
        MIRQ_IDLE,
        MIRQ_OPCODE,
        MIRQ_OPERAND,
        MIRQ_PUSH,
        MIRQ_FINISH
    } mirq_state_t;

    // Instruction events from the core, each a one-cycle pulse
    typedef struct packed {
        logic boundary;
        logic ei;
        logic di;
        logic sel_im0;
        logic sel_im1;
        logic sel_im2;
        logic set_mix;
        logic clr_mix;
        logic adl_wr;
        logic adl_val;
    } mirq_core_ctl_t;

    // One byte written to memory
    typedef struct packed {
        logic wr;
        logic [23:0] addr;
        logic [7:0] data;
    } mirq_mem_wr_t;

    // Loads handed back to the core
    typedef struct packed {
        logic pc_load;
        logic [23:0] pc_val;
        logic sp_load;
        logic sp_long;
        logic [23:0] sp_val;
    } mirq_load_t;

    typedef struct packed {
        mirq_state_t st;
        logic busy;
        logic done;
        logic iack;
        logic nop;
        logic maskable_enable_flag;
        logic enable_flag_shadow;
        logic long_address_mode_bit;
        logic mixed_mode_irq_bit;
        logic [1:0] im_mode;
        logic adl_e;
        logic mixed_mode_irq_bit_e;
        logic lng;
        logic [23:0] ret_pc;
        logic [15:0] opnd;
        logic [1:0] opnd_cnt;
        logic [23:0] target;
        logic [2:0] push_idx;
        mirq_mem_wr_t mem;
        mirq_load_t ld;
    } mirq_regs_t;

endpackage

// [hw/mirq_push_byte.sv]
// Picks the stack address and byte for one push step of the response.
// Assumes the caller walks the index from zero up to the count it returns.
`timescale 1ns/100ps
`include "mirq_regs.svh"
module mirq_push_byte
    import mirq_pkg::*;
(
    // Mode at entry
    input wire logic adl_in,
    input wire logic mixed_mode_irq_bit_in,
    // Pointers and return address
    input wire logic [7:0] short_mode_page_base_in,
    input wire logic [15:0] sps_in,
    input wire logic [23:0] spl_in,
    input wire logic [23:0] ret_pc_in,
    input wire logic [2:0] idx_in,
    // Results
    output logic [23:0] addr_out,
    output logic [7:0] data_out,
    output logic [2:0] count_out,
    output logic [23:0] sp_end_out
);
    logic lng;
    logic [2:0] cnt;
    logic [23:0] spl_step;
    logic [15:0] sps_step;

    always_comb
    begin
        lng = adl_in | mixed_mode_irq_bit_in;
        cnt = adl_in ? `MIRQ_PUSH_LONG : `MIRQ_PUSH_SHORT;
        if (mixed_mode_irq_bit_in)
        begin
            cnt = cnt + 3'h1;
        end
        spl_step = spl_in - {21'h000000, idx_in} - 24'h000001;
        sps_step = sps_in - {13'h0000, idx_in} - 16'h0001;
        // Short stack wraps inside its page
        addr_out = lng ? spl_step : {short_mode_page_base_in, sps_step};
        sp_end_out = lng ? (spl_in - {21'h000000, cnt}) : {short_mode_page_base_in, sps_in - {13'h0000, cnt}};
        // High bytes first so the return address sits little-endian
        data_out = `MIRQ_ZERO_BYTE;
        if (adl_in)
        begin
            case (idx_in)
                3'h0: data_out = ret_pc_in[23:16];
                3'h1: data_out = ret_pc_in[15:8];
                3'h2: data_out = ret_pc_in[7:0];
                default: data_out = `MIRQ_MIX_FROM_LONG;
            endcase
        end
        else
        begin
            case (idx_in)
                3'h0: data_out = ret_pc_in[15:8];
                3'h1: data_out = ret_pc_in[7:0];
                default: data_out = `MIRQ_MIX_FROM_SHORT;
            endcase
        end
        count_out = cnt;
    end
endmodule

// [sim/mirq_mode0_sva.sv]
// Checker of the mode 0 maskable response sequencer.
// Assumes pointers and return address stay steady while busy.
`timescale 1ns/100ps
module mirq_mode0_sva
    import mirq_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // Inputs
    input wire mirq_core_ctl_t ctl_in,
    input wire logic irq_req_in,
    input wire logic [23:0] pc_in,
    input wire logic [7:0] short_mode_page_base_in,
    input wire logic [15:0] sps_in,
    input wire logic [7:0] ack_data_in,
    // Outputs
    input wire logic iack_out,
    input wire mirq_mem_wr_t mem_out,
    input wire mirq_load_t load_out,
    input wire logic maskable_enable_flag_out,
    input wire logic enable_flag_shadow_out,
    input wire logic long_address_mode_bit_out,
    input wire logic mixed_mode_irq_bit_out,
    input wire logic [1:0] irq_mode_out,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic nop_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    wire lng = long_address_mode_bit_out;
    wire mx = mixed_mode_irq_bit_out;
    wire rst_op = (ack_data_in & 8'hC7) == 8'hC7;
    wire call_op = ack_data_in == 8'hCD;
    wire flag = maskable_enable_flag_out;
    wire acc = ctl_in.boundary & irq_req_in & flag & ~ctl_in.ei & ~busy_out & ~done_out;
    // First acknowledge cycle of a response
    sequence s_first;
        $rose(busy_out) && iack_out;
    endsequence
    accept_ack_a: assert property (acc && irq_mode_out == 2'h0 |=> iack_out && busy_out)
        else $error("no acknowledge after accept");
    refuse_flag_a: assert property (ctl_in.boundary && !flag && !busy_out |=> !busy_out)
        else $error("accepted while disabled");
    refuse_ei_a: assert property (ctl_in.boundary && ctl_in.ei && !busy_out |=> !busy_out)
        else $error("accepted on enable boundary");
    refuse_mode_a: assert property (ctl_in.boundary && irq_mode_out != 2'h0 |=> !$rose(busy_out))
        else $error("accepted outside mode 0");
    nop_end_a: assert property (s_first ##0 (!rst_op && !call_op)
        |=> done_out && nop_out && !busy_out)
        else $error("bad byte not a no-operation");
    flag_clear_a: assert property (done_out && !nop_out |-> !flag && !enable_flag_shadow_out)
        else $error("enable flags not cleared");
    short_target_a: assert property (s_first ##0 (rst_op && !lng && !mx) |-> ##4 done_out
        && load_out.pc_val[15:0] == {8'h00, $past(ack_data_in, 4) & 8'h38})
        else $error("short restart target wrong");
    short_push_a: assert property (s_first ##0 (rst_op && !lng && !mx) |-> ##2 mem_out.wr
        && mem_out.addr == {short_mode_page_base_in, sps_in - 16'h1} && mem_out.data == pc_in[15:8])
        else $error("short push wrong");
    long_operands_a: assert property (s_first ##0 (call_op && (lng || mx))
        |=> iack_out[*3] ##1 !iack_out)
        else $error("long call operand count wrong");
    mixed_push_a: assert property (s_first ##0 (rst_op && !lng && mx) |-> ##2 mem_out.wr[*2]
        ##1 (mem_out.wr && mem_out.data == 8'h02) ##1 !mem_out.wr)
        else $error("mixed push from short wrong");
    long_mixed_a: assert property (s_first ##0 (rst_op && lng && mx) |-> ##2 mem_out.wr[*3]
        ##1 (mem_out.wr && mem_out.data == 8'h03) ##1 !mem_out.wr)
        else $error("mixed push from long wrong");
endmodule

bind mirq_mode0_seq mirq_mode0_sva u_sva (.*);

// [sim/mirq_periph.sv]
// Peripheral model answering acknowledge cycles with bench bytes.
// Assumes one byte wanted per high cycle of the acknowledge line.
`timescale 1ns/100ps
module mirq_periph
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic arst_n_in,
    // Sequencer side
    input wire logic iack_in,
    input wire logic busy_in,
    input wire logic [31:0] seq_in,
    output logic [7:0] data_out
);
    logic [1:0] idx_ff;
    logic [7:0] last_ff;
    // Bench gives a restart, call or stray byte, never a suffix
    // Released bus shows the inverse of the last byte (FFh after reset), so the last byte driven never stays on it
    assign data_out = iack_in ? seq_in[8 * idx_ff +: 8] : ~last_ff;
    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            idx_ff <= 2'h0;
            last_ff <= 8'h00;
        end
        else if (iack_in)
        begin
            idx_ff <= idx_ff + 2'h1;
            last_ff <= data_out;
        end
        else if (!busy_in)
            idx_ff <= 2'h0;
    end
endmodule

// [sim/tb_maskable_irq_mode0_response.sv]
// Bench of the mode 0 maskable response sequencer.
// Assumes the peripheral model answers every acknowledge cycle.
`timescale 1ns/100ps
module tb_maskable_irq_mode0_response;
    import mirq_pkg::*;
    logic ref_clk_in, arst_n_in, irq_req_in, iack_out, busy_out, done_out, nop_out;
    logic maskable_enable_flag_out, enable_flag_shadow_out;
    logic long_address_mode_bit_out, mixed_mode_irq_bit_out;
    logic [1:0] irq_mode_out;
    logic [7:0] short_mode_page_base_in, ack_data_in;
    logic [15:0] sps_in;
    logic [23:0] pc_in, spl_in;
    logic [31:0] seq;
    logic [23:0] wa[8];
    logic [7:0] wd[8];
    logic ta, tm;
    mirq_core_ctl_t ctl_in;
    mirq_mem_wr_t mem_out;
    mirq_load_t load_out;
    int nw, mismatches, total_checks, cyc;

    mirq_mode0_seq dut (.*);
    mirq_periph peer (.ref_clk_in, .arst_n_in, .iack_in(iack_out), .busy_in(busy_out),
        .seq_in(seq), .data_out(ack_data_in));

    initial
    begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Timeout well above the few hundred cycles needed
    always @(posedge ref_clk_in)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            mismatches++;
            conclude();
        end
    end

    always @(negedge ref_clk_in)
        if (mem_out.wr === 1'b1 && nw < 8)
        begin
            wa[nw] = mem_out.addr;
            wd[nw] = mem_out.data;
            nw++;
        end

    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic pulse(input logic [9:0] c);
        @(posedge ref_clk_in);
        ctl_in <= c;
        @(posedge ref_clk_in);
        ctl_in <= '0;
    endtask

    task automatic setm(input logic a, input logic m);
        pulse(10'h002 | {9'h000, a});
        pulse(m ? 10'h008 : 10'h004);
        ta = a;
        tm = m;
    endtask

    // Request, enable, then accept at a boundary and check pushes and loads
    task automatic svc(input logic [31:0] b, input logic [23:0] e, input logic n);
        logic [23:0] base;
        logic [7:0] ex[4];
        int k;
        int np;
        @(posedge ref_clk_in);
        seq <= b;
        irq_req_in <= 1'b1;
        pulse(10'h300);
        @(negedge ref_clk_in);
        chk(busy_out, 1'b0);
        nw = 0;
        pulse(10'h200);
        irq_req_in <= 1'b0;
        k = 0;
        do
            @(negedge ref_clk_in);
        while (done_out !== 1'b1 && ++k < 30);
        chk(done_out, 1'b1);
        chk(nop_out, n);
        chk({maskable_enable_flag_out, enable_flag_shadow_out}, {n, n});
        chk({load_out.pc_load, load_out.sp_load}, {~n, ~n});
        chk(mixed_mode_irq_bit_out, tm);
        base = (ta | tm) ? spl_in : {short_mode_page_base_in, sps_in};
        np = 0;
        if (!n)
        begin
            if (ta) ex[np++] = pc_in[23:16];
            ex[np++] = pc_in[15:8];
            ex[np++] = pc_in[7:0];
            if (tm) ex[np++] = ta ? 8'h03 : 8'h02;
            chk(load_out.pc_val & ((ta | tm) ? 24'hFFFFFF : 24'h00FFFF), e);
            chk(load_out.sp_val, base - 24'(np));
            chk(long_address_mode_bit_out, ta | tm);
            chk(load_out.sp_long, ta | tm);
            ta = ta | tm;
        end
        chk(24'(nw), 24'(np));
        for (k = 0; k < np; k++)
        begin
            chk(wa[k], base - 24'(k + 1));
            chk(wd[k], ex[k]);
        end
    endtask

    initial
    begin
        arst_n_in = 1'b0;
        irq_req_in = 1'b0;
        ctl_in = '0;
        seq = '0;
        pc_in = 24'hA1B2C3;
        short_mode_page_base_in = 8'h5E;
        sps_in = 16'h8000;
        spl_in = 24'h3C0100;
        {mismatches, total_checks, nw, cyc, ta, tm} = '0;
        repeat (10) @(posedge ref_clk_in);
        arst_n_in <= 1'b1;
        @(negedge ref_clk_in);
        chk({maskable_enable_flag_out, enable_flag_shadow_out, irq_mode_out}, 24'h0);
        @(posedge ref_clk_in);
        irq_req_in <= 1'b1;
        pulse(10'h200);
        @(negedge ref_clk_in);
        chk(busy_out, 1'b0);
        for (int i = 0; i < 8; i++)
            svc({24'h0, 8'hC7 | 8'(i * 8)}, 24'(i * 8), 1'b0);
        svc(32'h009A34CD, 24'h009A34, 1'b0);
        svc(32'h000000C6, 24'h0, 1'b1);
        svc(32'h00000000, 24'h0, 1'b1);
        setm(1'b1, 1'b0);
        svc(32'h7E9A34CD, 24'h7E9A34, 1'b0);
        setm(1'b0, 1'b1);
        svc(32'h000000FF, 24'h000038, 1'b0);
        setm(1'b1, 1'b1);
        svc(32'h000000EF, 24'h000028, 1'b0);
        pulse(10'h020);
        irq_req_in <= 1'b1;
        pulse(10'h300);
        pulse(10'h200);
        @(negedge ref_clk_in);
        chk({busy_out, irq_mode_out}, 24'h1);
        pulse(10'h040);
        setm(1'b0, 1'b0);
        svc(32'h000000D7, 24'h000010, 1'b0);
        conclude();
    end
endmodule
